// File: design/csm_pkg.sv
package csm_pkg;

   // ****************************************************************
   // Register indices (byte address is four times the index)
   // ****************************************************************
   localparam logic [15:0] IDX_MB_BASE      = 16'hd500;
   localparam logic [15:0] IDX_MB_LAST      = 16'hd6ff;
   localparam logic [15:0] IDX_MASK_BASE    = 16'hd700;
   localparam logic [15:0] IDX_MASK_LAST    = 16'hd71f;
   localparam logic [15:0] IDX_IRQ_EN       = 16'hd72c;
   localparam logic [15:0] IDX_CTRL_BASE    = 16'hd7a0;
   localparam logic [15:0] IDX_CTRL_LAST    = 16'hd7bf;
   localparam logic [15:0] IDX_OP_CTRL      = 16'hd7c0;
   localparam logic [15:0] IDX_STATUS       = 16'hd7c2;
   localparam logic [15:0] IDX_BIT_TIMING   = 16'hd7c4;
   localparam logic [15:0] IDX_RX_ERR_CNT   = 16'hd7ce;
   localparam logic [15:0] IDX_TX_ERR_CNT   = 16'hd7cf;
   localparam logic [15:0] IDX_TIMESTAMP    = 16'hd7d4;
   localparam logic [15:0] IDX_FILTER_SUP   = 16'hd7d6;

   // ****************************************************************
   // Status bit positions
   // ****************************************************************
   localparam int ST_RESET      = 0;
   localparam int ST_HALT       = 1;
   localparam int ST_ERR_PASS   = 3;
   localparam int ST_BUS_OFF    = 4;
   localparam int ST_TX_BUSY    = 5;
   localparam int ST_RX_BUSY    = 6;
   localparam int ST_ANY_FRESH  = 8;
   localparam int ST_ANY_SENT   = 9;
   localparam int ST_RXQ_FILLED = 10;
   localparam int ST_TXQ_ROOM   = 11;
   localparam int ST_ANY_LOST   = 12;
   localparam int ST_RXQ_LOST   = 13;
   localparam int ST_ANY_ABORT  = 14;
   localparam int ST_ERROR      = 15;

   // ****************************************************************
   // Bit timing fields
   // ****************************************************************
   localparam int BT_PRESC_LSB = 0;
   localparam int BT_TSEG1_LSB = 12;
   localparam int BT_TSEG2_LSB = 16;
   localparam int BT_SJW_LSB   = 20;
   localparam logic [9:0] RST_PRESC = 10'h000;
   localparam logic [3:0] RST_TSEG1 = 4'h3;
   localparam logic [2:0] RST_TSEG2 = 3'h1;
   localparam logic [1:0] RST_SJW   = 2'h0;
   localparam logic [3:0] TSEG1_MIN = 4'h3;
   localparam logic [2:0] TSEG2_MIN = 3'h1;

   // ****************************************************************
   // Mailbox control byte and mailbox word layout
   // ****************************************************************
   localparam int MC_FRESH   = 0;
   localparam int MC_SENT    = 1;
   localparam int MC_LOST_AB = 2;
   localparam int MC_ONESHOT = 4;
   localparam int MC_RX_REQ  = 6;
   localparam int MC_TX_REQ  = 7;
   localparam int MB_STD_LSB = 18;
   localparam int MB_RTR_BIT = 30;
   localparam int MB_IDE_BIT = 31;
   localparam int MB_DATA_LSB  = 48;
   localparam int MB_TS_LO_LSB = 112;
   localparam int MB_TS_HI_LSB = 120;

   // ****************************************************************
   // Operating control
   // ****************************************************************
   localparam int OC_MODE_LSB  = 0;
   localparam int OC_LOST_MODE = 2;
   localparam logic [1:0] MODE_NORMAL  = 2'h0;
   localparam logic [1:0] MODE_RESET   = 2'h1;
   localparam logic [1:0] MODE_HALT    = 2'h2;
   localparam logic [1:0] MODE_ILLEGAL = 2'h3;

endpackage : csm_pkg

// File: design/csm_top.sv
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// Functional notes
// - Status bit 3 shows error-passive state.
// - Status bit 4 shows bus-off state.
// - Status bit 5 is set while transmitting or bus-off.
// - Status bit 6 is set while receiving, clear when idle or transmitting.
// - Status bit 8 is OR of all new-data flags.
// - Status bit 9 is OR of all sent flags.
// - Status bit 10 set when receive queue holds a message.
// - Status bit 11 clear when transmit queue full, set otherwise.
// - Status bit 12 is OR of mailbox message-lost flags.
// - Status bit 13 mirrors the receive queue lost flag.
// - Status bit 14 is OR of abort-complete flags.
// - Status bit 15 set once a protocol error is detected.
// - 32-bit mailbox interrupt enable register, one bit per mailbox.
// - Prescaler value P divides the protocol clock by P plus one.
// - First time segment is field plus one quanta; codes 0-2 illegal.
// - Second time segment in bits 18-16 is field plus one; 0 illegal.
// - Jump width in bits 21-20 is field plus one quanta.
// - Receive mailbox bit 2 set when stored message overwritten or overrun.
// - Transmit mailbox bit 2 set only when a requested abort succeeded.
// - Control bit 4 gives one reception or one transmit attempt only.
// - Id word: extended part low, standard above, bit 30 remote, 31 extended.
// - Each mailbox keeps a 16-bit receive timestamp in bits 127-112.
// - Mode field: 00 normal, 01 reset, 10 halt; 11 never used.
module csm_top
   import csm_pkg::*;
(
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [17:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Protocol engine state
   input  wire logic        eng_tx_active,
   input  wire logic        eng_rx_active,
   input  wire logic        eng_err_passive,
   input  wire logic        eng_bus_off,
   input  wire logic        eng_error,
   input  wire logic        rxq_not_empty,
   input  wire logic        txq_not_full,
   input  wire logic        rx_queue_lost_flag,
   input  wire logic [7:0]  eng_rx_err_cnt,
   input  wire logic [7:0]  eng_tx_err_cnt,
   // Protocol engine mailbox events
   input  wire logic        rx_store,
   input  wire logic [4:0]  rx_mb,
   input  wire logic [31:0] rx_id,
   input  wire logic [63:0] rx_data,
   input  wire logic        tx_done,
   input  wire logic        tx_fail,
   input  wire logic        abort_ok,
   input  wire logic [4:0]  tx_mb,
   // Configuration towards the engine
   output logic [31:0]      tx_request_bit,
   output logic [31:0]      rx_request_bit,
   output logic [31:0]      mb_irq_enable,
   output logic [1:0]       op_mode,
   output logic             tq_tick,
   output logic [4:0]       tseg1_len,
   output logic [3:0]       tseg2_len,
   output logic [2:0]       sjw_len
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [127:0] mb_ram [0:31];
   logic [31:0]  mask_set [0:7];
   logic [31:0]  fresh_message_flag;
   logic [31:0]  sent_done_flag;
   logic [31:0]  lost_message_flag;
   logic [31:0]  abort_done_flag;
   logic [31:0]  oneshot;
   logic [15:0]  status;
   logic [15:0]  filter_sup;
   logic [15:0]  ts_cnt;
   logic [9:0]   presc;
   logic [3:0]   tseg1;
   logic [2:0]   tseg2;
   logic [1:0]   sjw;
   logic         lost_mode;
   logic         err_seen;
   logic [9:0]   tq_cnt;
   logic [4:0]   q_cnt;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   logic [15:0] idx;
   logic [15:0] mb_off;
   logic [15:0] mk_off;
   logic [15:0] ct_off;
   logic        in_mb;
   logic        in_mask;
   logic        in_ctrl;
   logic [4:0]  mb_sel;
   logic [1:0]  mb_word;
   logic [2:0]  mk_sel;
   logic [4:0]  ct_sel;
   logic        wr_go;
   logic [31:0] next_rdata;
   logic        next_err;

   assign idx     = paddr[17:2];
   assign mb_off  = idx - IDX_MB_BASE;
   assign mk_off  = idx - IDX_MASK_BASE;
   assign ct_off  = idx - IDX_CTRL_BASE;
   assign in_mb   = idx >= IDX_MB_BASE && idx <= IDX_MB_LAST
                    && mb_off[1:0] == 2'h0;
   assign in_mask = idx >= IDX_MASK_BASE && idx <= IDX_MASK_LAST
                    && mk_off[1:0] == 2'h0;
   assign in_ctrl = idx >= IDX_CTRL_BASE && idx <= IDX_CTRL_LAST;
   assign mb_sel  = mb_off[8:4];
   assign mb_word = mb_off[3:2];
   assign mk_sel  = mk_off[4:2];
   assign ct_sel  = ct_off[4:0];
   // Writes land only on the edge that completes the access
   assign wr_go   = psel && penable && pready && pwrite;

   // Bit 2 shows the lost flag for receive boxes, abort flag otherwise
   function automatic logic [7:0] ctrl_byte(input logic [4:0] j);
      logic [7:0] b;
      b = 8'h00;
      b[MC_FRESH]   = fresh_message_flag[j];
      b[MC_SENT]    = sent_done_flag[j];
      b[MC_LOST_AB] = (rx_request_bit[j] && !tx_request_bit[j]) ?
                      lost_message_flag[j] : abort_done_flag[j];
      b[MC_ONESHOT] = oneshot[j];
      b[MC_RX_REQ]  = rx_request_bit[j];
      b[MC_TX_REQ]  = tx_request_bit[j];
      return b;
   endfunction : ctrl_byte

   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err   = 1'b0;
      if (in_mb) begin
         next_rdata = mb_ram[mb_sel][{mb_word, 5'h00} +: 32];
      end else if (in_mask) begin
         next_rdata = mask_set[mk_sel];
      end else if (in_ctrl) begin
         next_rdata = {24'h00_0000, ctrl_byte(ct_sel)};
      end else begin
         unique case (idx)
            IDX_IRQ_EN:     next_rdata = mb_irq_enable;
            IDX_OP_CTRL:    next_rdata = {29'h0, lost_mode, op_mode};
            IDX_STATUS:     next_rdata = {16'h0000, status};
            IDX_BIT_TIMING: next_rdata = {10'h000, sjw, 1'b0, tseg2,
                                          tseg1, 2'h0, presc};
            IDX_RX_ERR_CNT: next_rdata = {24'h00_0000, eng_rx_err_cnt};
            IDX_TX_ERR_CNT: next_rdata = {24'h00_0000, eng_tx_err_cnt};
            IDX_TIMESTAMP:  next_rdata = {16'h0000, ts_cnt};
            IDX_FILTER_SUP: next_rdata = {16'h0000, filter_sup};
            default:        next_err   = 1'b1;
         endcase
      end
   end

   // One wait-free access cycle; data latched at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         if (psel && !penable) begin
            prdata  <= pwrite ? 32'h0000_0000 : next_rdata;
            pslverr <= next_err;
         end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // Plain software registers
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mb_irq_enable <= 32'h0000_0000;
         filter_sup    <= 16'h0000;
         lost_mode     <= 1'b0;
         op_mode       <= MODE_RESET;
         for (int k = 0; k < 8; k++) begin
            mask_set[k] <= 32'h0000_0000;
         end
      end else if (wr_go) begin
         if (idx == IDX_IRQ_EN) begin
            mb_irq_enable <= pwdata;
         end
         if (idx == IDX_FILTER_SUP) begin
            filter_sup <= pwdata[15:0];
         end
         if (in_mask) begin
            mask_set[mk_sel] <= pwdata;
         end
         if (idx == IDX_OP_CTRL) begin
            lost_mode <= pwdata[OC_LOST_MODE];
            // The unused code is dropped so the engine never sees it
            if (pwdata[OC_MODE_LSB +: 2] != MODE_ILLEGAL) begin
               op_mode <= pwdata[OC_MODE_LSB +: 2];
            end
         end
      end
   end

   // Illegal segment codes reject the whole write; old timing stays
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc <= RST_PRESC;
         tseg1 <= RST_TSEG1;
         tseg2 <= RST_TSEG2;
         sjw   <= RST_SJW;
      end else if (wr_go && idx == IDX_BIT_TIMING
                   && pwdata[BT_TSEG1_LSB +: 4] >= TSEG1_MIN
                   && pwdata[BT_TSEG2_LSB +: 3] >= TSEG2_MIN) begin
         presc <= pwdata[BT_PRESC_LSB +: 10];
         tseg1 <= pwdata[BT_TSEG1_LSB +: 4];
         tseg2 <= pwdata[BT_TSEG2_LSB +: 3];
         sjw   <= pwdata[BT_SJW_LSB +: 2];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tseg1_len <= 5'({1'b0, RST_TSEG1} + 5'h01);
         tseg2_len <= 4'({1'b0, RST_TSEG2} + 4'h1);
         sjw_len   <= 3'({1'b0, RST_SJW} + 3'h1);
      end else begin
         tseg1_len <= {1'b0, tseg1} + 5'h01;
         tseg2_len <= {1'b0, tseg2} + 4'h1;
         sjw_len   <= {1'b0, sjw} + 3'h1;
      end
   end

   // ****************************************************************
   // Time quantum, bit time and timestamp
   // ****************************************************************
   logic [4:0] bit_last;
   assign bit_last = tseg1_len + 5'({1'b0, tseg2_len});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tq_cnt  <= 10'h000;
         tq_tick <= 1'b0;
      end else if (op_mode != MODE_NORMAL) begin
         tq_cnt  <= 10'h000;
         tq_tick <= 1'b0;
      end else begin
         tq_tick <= tq_cnt >= presc;
         tq_cnt  <= (tq_cnt >= presc) ? 10'h000 : tq_cnt + 10'h001;
      end
   end

   // Sync quantum plus both segments make one bit time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_cnt  <= 5'h00;
         ts_cnt <= 16'h0000;
      end else if (op_mode != MODE_NORMAL) begin
         q_cnt  <= 5'h00;
      end else if (tq_tick) begin
         if (q_cnt >= bit_last) begin
            q_cnt  <= 5'h00;
            ts_cnt <= ts_cnt + 16'h0001;
         end else begin
            q_cnt <= q_cnt + 5'h01;
         end
      end
   end

   // ****************************************************************
   // Mailbox control flags
   // ****************************************************************
   logic rx_acc;
   logic rx_write;
   logic wr_ctrl;
   assign rx_acc   = rx_store && rx_request_bit[rx_mb]
                     && !tx_request_bit[rx_mb];
   // Overrun mode keeps the unread message and drops the new one
   assign rx_write = rx_acc && !(lost_mode && fresh_message_flag[rx_mb]);
   assign wr_ctrl  = wr_go && in_ctrl;

   // Software clears a flag by writing 0; a same-cycle event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fresh_message_flag <= 32'h0000_0000;
         sent_done_flag     <= 32'h0000_0000;
         lost_message_flag  <= 32'h0000_0000;
         abort_done_flag    <= 32'h0000_0000;
         oneshot            <= 32'h0000_0000;
         rx_request_bit     <= 32'h0000_0000;
         tx_request_bit     <= 32'h0000_0000;
      end else begin
         for (int j = 0; j < 32; j++) begin
            if (wr_ctrl && ct_sel == 5'(j)) begin
               fresh_message_flag[j] <= fresh_message_flag[j]
                                        && pwdata[MC_FRESH];
               sent_done_flag[j]     <= sent_done_flag[j]
                                        && pwdata[MC_SENT];
               lost_message_flag[j]  <= lost_message_flag[j]
                                        && pwdata[MC_LOST_AB];
               abort_done_flag[j]    <= abort_done_flag[j]
                                        && pwdata[MC_LOST_AB];
               oneshot[j]            <= pwdata[MC_ONESHOT];
               rx_request_bit[j]     <= pwdata[MC_RX_REQ];
               tx_request_bit[j]     <= pwdata[MC_TX_REQ];
            end
            if (rx_acc && rx_mb == 5'(j)) begin
               if (fresh_message_flag[j]) begin
                  lost_message_flag[j] <= 1'b1;
               end
               fresh_message_flag[j] <= 1'b1;
               if (oneshot[j]) begin
                  rx_request_bit[j] <= 1'b0;
               end
            end
            if (tx_mb == 5'(j)) begin
               if (tx_done) begin
                  sent_done_flag[j] <= 1'b1;
                  tx_request_bit[j] <= 1'b0;
               end
               if (tx_fail && oneshot[j]) begin
                  tx_request_bit[j] <= 1'b0;
               end
               if (abort_ok && !tx_done) begin
                  abort_done_flag[j] <= 1'b1;
               end
            end
         end
      end
   end

   // ****************************************************************
   // Mailbox message storage
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int m = 0; m < 32; m++) begin
            mb_ram[m] <= 128'h0;
         end
      end else begin
         if (wr_go && in_mb) begin
            mb_ram[mb_sel][{mb_word, 5'h00} +: 32] <= pwdata;
         end
         if (rx_write) begin
            mb_ram[rx_mb][31:0]                  <= rx_id;
            mb_ram[rx_mb][MB_DATA_LSB +: 64]     <= rx_data;
            mb_ram[rx_mb][MB_TS_LO_LSB +: 8]     <= ts_cnt[7:0];
            mb_ram[rx_mb][MB_TS_HI_LSB +: 8]     <= ts_cnt[15:8];
         end
      end
   end

   // ****************************************************************
   // Status
   // ****************************************************************
   logic [31:0] rx_cfg;
   logic [31:0] tx_cfg;
   assign rx_cfg = rx_request_bit & ~tx_request_bit;
   assign tx_cfg = ~rx_cfg;

   // Error flag stays until software parks the block in reset mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_seen <= 1'b0;
      end else if (eng_error) begin
         err_seen <= 1'b1;
      end else if (op_mode == MODE_RESET) begin
         err_seen <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 16'h0000;
      end else begin
         status                <= 16'h0000;
         status[ST_RESET]      <= op_mode == MODE_RESET;
         status[ST_HALT]       <= op_mode == MODE_HALT;
         status[ST_ERR_PASS]   <= eng_err_passive;
         status[ST_BUS_OFF]    <= eng_bus_off;
         status[ST_TX_BUSY]    <= eng_tx_active || eng_bus_off;
         status[ST_RX_BUSY]    <= eng_rx_active && !eng_tx_active;
         status[ST_ANY_FRESH]  <= |fresh_message_flag;
         status[ST_ANY_SENT]   <= |sent_done_flag;
         status[ST_RXQ_FILLED] <= rxq_not_empty;
         status[ST_TXQ_ROOM]   <= txq_not_full;
         status[ST_ANY_LOST]   <= |(lost_message_flag & rx_cfg);
         status[ST_RXQ_LOST]   <= rx_queue_lost_flag;
         status[ST_ANY_ABORT]  <= |(abort_done_flag & tx_cfg);
         status[ST_ERROR]      <= err_seen || eng_error;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_err_passive_flag: assert property (
      ##1 status[ST_ERR_PASS] == $past(eng_err_passive))
      else $error("error-passive flag wrong");
   a_bus_off_flag: assert property (
      eng_bus_off |=> status[ST_BUS_OFF] && status[ST_TX_BUSY])
      else $error("bus-off flags wrong");
   a_rx_busy_flag: assert property (
      eng_tx_active |=> !status[ST_RX_BUSY])
      else $error("receive flag set while transmitting");
   a_fresh_or: assert property (
      ##1 status[ST_ANY_FRESH] == $past(|fresh_message_flag))
      else $error("new-data summary wrong");
   a_error_sticky: assert property (
      eng_error && op_mode != MODE_RESET |=> status[ST_ERROR] [*2])
      else $error("error flag not held");
   a_presc_bound: assert property (
      op_mode == MODE_NORMAL && tq_cnt == presc && $stable(presc)
      |=> tq_tick && tq_cnt == 10'h000)
      else $error("quantum tick not at prescaler end");
   a_tseg_legal: assert property (
      tseg1 >= TSEG1_MIN && tseg2 >= TSEG2_MIN
      && tseg1_len >= 5'h04 && tseg2_len >= 4'h2)
      else $error("illegal segment length");
   a_mode_legal: assert property (
      op_mode != MODE_ILLEGAL)
      else $error("illegal operating mode");
   a_lost_on_overrun: assert property (
      rx_acc && fresh_message_flag[rx_mb]
      |=> lost_message_flag[$past(rx_mb)])
      else $error("lost flag not set");
   a_oneshot_tx: assert property (
      tx_fail && oneshot[tx_mb] |=> !tx_request_bit[$past(tx_mb)])
      else $error("one-shot transmit rearmed");
   a_timestamp_kept: assert property (
      rx_write && !(wr_go && in_mb)
      |=> mb_ram[$past(rx_mb)][MB_TS_LO_LSB +: 16] == $past(ts_cnt))
      else $error("timestamp not stored");

   c_reception: cover property (rx_write ##1 status[ST_ANY_FRESH]);
   c_overrun: cover property (rx_acc && fresh_message_flag[rx_mb]);
   c_sent: cover property (tx_done ##1 status[ST_ANY_SENT]);
   c_abort: cover property (abort_ok ##2 status[ST_ANY_ABORT]);

endmodule : csm_top

// File: tb/csm_eng_model.sv
`timescale 1ns/1ps
module csm_eng_model (
   // Clock
   input  wire logic        pclk,
   // Levels and event pulses (error, store, done, fail, abort)
   output logic      [6:0]  lv,
   output logic      [4:0]  ev,
   output logic      [4:0]  mb,
   output logic      [31:0] id
);
   initial begin
      lv = '0;
      ev = '0;
      mb = '0;
      id = '0;
   end
   // Level inputs change only here, so the model stays their one driver
   task automatic levels(input logic [6:0] v);
      lv <= v;
   endtask : levels
   // One event per edge; id scrambled after so stale values never match
   task automatic pulse(input int k, input logic [4:0] m,
                        input logic [31:0] i);
      @(posedge pclk);
      ev[k] <= 1'b1;
      mb    <= m;
      id    <= i;
      @(posedge pclk);
      ev    <= '0;
      id    <= ~i;
      @(posedge pclk);
   endtask : pulse
endmodule : csm_eng_model

// File: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import csm_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, er;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pready, pslverr, tq_tick;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd, txr, rxr, irq, id;
   logic [6:0]  lv;
   logic [4:0]  ev, mb, t1;
   logic [3:0]  t2;
   logic [2:0]  sj;
   logic [1:0]  op_mode;
   int          n_mismatch = 0, checked = 0, k, tk;
   localparam logic [7:0][15:0] EXP = {16'h0020, 16'h2000, 16'h0800,
      16'h0400, 16'h0030, 16'h0008, 16'h0040, 16'h0020};
   always #5 pclk = ~pclk;
   csm_eng_model eng (.pclk(pclk), .lv(lv), .ev(ev), .mb(mb), .id(id));
   csm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .eng_tx_active(lv[0]), .eng_rx_active(lv[1]),
      .eng_err_passive(lv[2]), .eng_bus_off(lv[3]), .eng_error(ev[0]),
      .rxq_not_empty(lv[4]), .txq_not_full(lv[5]),
      .rx_queue_lost_flag(lv[6]), .eng_rx_err_cnt(8'h5a),
      .eng_tx_err_cnt(8'hc3), .rx_store(ev[1]), .rx_mb(mb), .rx_id(id),
      .rx_data({id, ~id}), .tx_done(ev[2]), .tx_fail(ev[3]),
      .abort_ok(ev[4]), .tx_mb(mb), .tx_request_bit(txr),
      .rx_request_bit(rxr), .mb_irq_enable(irq), .op_mode(op_mode),
      .tq_tick(tq_tick), .tseg1_len(t1), .tseg2_len(t2), .sjw_len(sj));
   // *****
   // Reporting and bus tasks
   // *****
   task automatic finish_test();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [15:0] x,
                      input logic [31:0] d = 32'h0);
      int n;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {x, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 9; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 9) begin
         n_mismatch++;
         finish_test();
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic st(input int b, input logic e);
      apb(1'b0, IDX_STATUS);
      chk("status bit", 32'(rd[b]), 32'(e));
   endtask : st
   // *****
   // Sequence
   // *****
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      chk("mode", 32'(op_mode), 32'(MODE_RESET));
      apb(1'b0, IDX_BIT_TIMING);
      chk("timing", rd, 32'h00013000);
      apb(1'b1, IDX_BIT_TIMING, 32'h003273ff);
      apb(1'b1, IDX_BIT_TIMING, 32'h003223ff);
      apb(1'b1, IDX_BIT_TIMING, 32'h003073ff);
      apb(1'b0, IDX_BIT_TIMING);
      chk("timing", rd, 32'h003273ff);
      chk("lens", 32'({t1, t2, sj}), 32'h41c);
      apb(1'b1, IDX_OP_CTRL, 32'h0);
      apb(1'b1, IDX_OP_CTRL, 32'h3);
      chk("mode", 32'(op_mode), 32'(MODE_NORMAL));
      apb(1'b1, IDX_BIT_TIMING, 32'h00327002);
      repeat (6) @(posedge pclk);
      tk = 0;
      repeat (30) @(posedge pclk) tk += int'(tq_tick === 1'b1);
      chk("ticks", tk, 32'd10);
      apb(1'b1, IDX_IRQ_EN, 32'h80000001);
      apb(1'b0, IDX_IRQ_EN);
      chk("irq en", rd, 32'h80000001);
      chk("irq pin", irq, 32'h80000001);
      apb(1'b0, 16'hd7e0);
      chk("unmapped", 32'(er), 32'h1);
      for (k = 0; k < 8; k++) begin
         eng.levels((k < 7) ? 7'(1 << k) : 7'h03);
         @(posedge pclk);
         apb(1'b0, IDX_STATUS);
         chk("status", rd, 32'(EXP[k]));
      end
      eng.levels(7'h20);
      eng.pulse(0, 5'd0, 32'h0);
      st(15, 1'b1);
      apb(1'b1, IDX_CTRL_BASE + 16'd3, 32'h40);
      eng.pulse(1, 5'd3, 32'h92345678);
      apb(1'b0, IDX_MB_BASE + 16'd48);
      chk("id", rd, 32'h92345678);
      st(8, 1'b1);
      eng.pulse(1, 5'd3, 32'h12345678);
      apb(1'b0, IDX_CTRL_BASE + 16'd3);
      chk("lost", rd, 32'h45);
      st(12, 1'b1);
      apb(1'b1, IDX_CTRL_BASE + 16'd3, 32'h40);
      st(8, 1'b0);
      st(12, 1'b0);
      apb(1'b1, IDX_CTRL_BASE + 16'd5, 32'h80);
      eng.pulse(4, 5'd5, 32'h0);
      apb(1'b0, IDX_CTRL_BASE + 16'd5);
      chk("abort", 32'(rd[2]), 32'h1);
      st(14, 1'b1);
      apb(1'b1, IDX_CTRL_BASE + 16'd6, 32'h80);
      eng.pulse(2, 5'd6, 32'h0);
      apb(1'b0, IDX_CTRL_BASE + 16'd6);
      chk("sent", 32'(rd[2:0]), 32'h2);
      st(9, 1'b1);
      apb(1'b1, IDX_CTRL_BASE + 16'd7, 32'h50);
      eng.pulse(1, 5'd7, 32'h00040001);
      apb(1'b0, IDX_CTRL_BASE + 16'd7);
      chk("one shot", rd, 32'h11);
      chk("rx req", 32'(rxr[7]), 32'h0);
      apb(1'b1, IDX_CTRL_BASE + 16'd8, 32'h90);
      chk("tx req", 32'(txr[8]), 32'h1);
      eng.pulse(3, 5'd8, 32'h0);
      chk("one shot tx", 32'(txr[8]), 32'h0);
      apb(1'b1, IDX_OP_CTRL, 32'h4);
      eng.pulse(1, 5'd3, 32'h0000aaaa);
      eng.pulse(1, 5'd3, 32'h0000bbbb);
      apb(1'b0, IDX_MB_BASE + 16'd48);
      chk("overrun", rd, 32'h0000aaaa);
      st(12, 1'b1);
      finish_test();
   end
endmodule : testbench
